//--- verilog/reconfig_status_defs.svh
// Constants for the reconfiguration cause and status record.
// Assumes inclusion by bare name from files that need the layout.
`ifndef RECONFIG_STATUS_DEFS_SVH
`define RECONFIG_STATUS_DEFS_SVH

`define CUR_WORD_W 32
`define PREV_REC_W 31
`define ADDR_W 24
`define WD_VAL_W 29
`define CUR_MSTATE_HI 31
`define CUR_MSTATE_LO 30
`define CUR_WD_EN_BIT 29
`define PREV_SRC_HI 30
`define PREV_SRC_LO 26
`define PREV_MSTATE_HI 25
`define PREV_MSTATE_LO 24
`define PAD_W 6
`define SRC_W 5
`define SRC_NONE 5'h00
`define SRC_CFG_RESET 5'h10
`define SRC_CRC 5'h08
`define SRC_ERR_PIN 5'h04
`define SRC_WATCHDOG 5'h02
`define SRC_FABRIC 5'h01
`define MSTATE_FACTORY 2'h0
`define MSTATE_APP_LOAD 2'h1
`define MSTATE_APP_USER 2'h2
`define MSTATE_RECONFIG 2'h3
`define INVALID_PREV 31'h7FFFFFFF
`define VIEW_FACTORY 2'h0
`define VIEW_APP_ONE 2'h1
`define VIEW_APP_TWO 2'h2
`define VIEW_PREV_ONE 2'h3
`define SEL_W 3
`define SEL_CUR_FACTORY 3'h0
`define SEL_CUR_APP_ONE 3'h1
`define SEL_CUR_APP_TWO 3'h2
`define SEL_PREV_ONE 3'h3
`define SEL_PREV_TWO 3'h4

`endif

//--- verilog/reconfig_status_pkg.sv
// Types shared by the reconfiguration status record files.
// Assumes the definitions header is on the include path.
`default_nettype none
`include "reconfig_status_defs.svh"

package reconfig_status_pkg;
  typedef logic [1:0] mstate_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`SRC_W-1:0] src_t;
  typedef logic [`PREV_REC_W-1:0] prev_rec_t;
  typedef logic [`CUR_WORD_W-1:0] cur_word_t;
  typedef logic [`SEL_W-1:0] sel_t;
endpackage

`default_nettype wire

//--- verilog/reconfig_source_pick.sv
// Priority pick of one reconfiguration source, one-hot result.
// Assumes synchronous raw source inputs, all active high.
`default_nettype none
`include "reconfig_status_defs.svh"

module reconfig_source_pick (
  input wire logic cfg_reset,
  input wire logic crc_error,
  input wire logic err_pin,
  input wire logic watchdog,
  input wire logic fabric_req,
  output logic [`SRC_W-1:0] onehot
);
  // Higher bit wins on a tie
  always_comb begin
    if (cfg_reset) begin
      onehot = `SRC_CFG_RESET; // see (R13)
    end else if (crc_error) begin
      onehot = `SRC_CRC;
    end else if (err_pin) begin
      onehot = `SRC_ERR_PIN;
    end else if (watchdog) begin
      onehot = `SRC_WATCHDOG;
    end else if (fabric_req) begin
      onehot = `SRC_FABRIC;
    end else begin
      onehot = `SRC_NONE;
    end
  end
endmodule

`default_nettype wire

//--- verilog/reconfig_cause_status_record.sv
// Reconfiguration cause and status record with capture into the shift path.
// Assumes one oscillator-domain clock and synchronous, active-high events.
// Summary of operation
// (R1) Record which of five causes triggered reconfiguration
// (R2) Current state is a 32-bit view word
// (R3) Master state in bits 31:30 always
// (R4) Bits 29:24 zero in address views
// (R5) Low 24 bits hold running boot address
// (R6) Application view one: watchdog enable bit 29
// (R7) Application view one: 29-bit time-out low bits
// (R8) Factory view in factory, else application views
// (R9) Layouts apply for serial and parallel schemes
// (R10) Two previous-state records kept for debugging
// (R11) Both 31 bits; one current, two before
// (R12) Bits 30:26 one-hot cause, fixed order
// (R13) Simultaneous causes: highest bit only flagged
// (R14) Bits 25:24 master state when leaving image
// (R15) Low 24 bits hold that image's address
// (R16) Premature previous capture returns invalid marker
// (R17) Capture copies chosen record into shift register
// (R18) Record updated after error, before factory load
// (R19) Fixed two-bit master state codes everywhere
`default_nettype none
`include "reconfig_status_defs.svh"

module reconfig_cause_status_record #(
  parameter int ADDR_W = `ADDR_W,
  parameter int WD_W = `WD_VAL_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] scheme_select_pins,
  input wire logic running_app,
  input wire logic app_user_mode,
  input wire logic [ADDR_W-1:0] boot_addr,
  input wire logic wd_enable,
  input wire logic [WD_W-1:0] wd_timeout,
  input wire logic crc_error,
  input wire logic external_error_pin,
  input wire logic fabric_reconfig_req,
  input wire logic external_config_reset_pin,
  input wire logic watchdog_timeout,
  input wire logic capture,
  input wire reconfig_status_pkg::sel_t capture_sel,
  output logic [`CUR_WORD_W-1:0] shift_data,
  output logic shift_valid,
  output logic [`CUR_WORD_W-1:0] current_state_word,
  output logic [`PREV_REC_W-1:0] previous_state_record_one,
  output logic [`PREV_REC_W-1:0] previous_state_record_two,
  output logic record_updated,
  output logic scheme_supported
);
  import reconfig_status_pkg::*;

  typedef enum logic [2:0] {
    ST_FACTORY = 3'h1,
    ST_APP = 3'h2,
    ST_LEAVING = 3'h4
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic app_seen;
    prev_rec_t rec_one;
    prev_rec_t rec_two;
    addr_t run_addr;
    cur_word_t shift;
    logic shift_vld;
    logic updated;
  } state_s;

  state_s st_q;
  state_s st_d;
  src_t cause;
  logic any_cause;
  mstate_t mstate;
  cur_word_t view_fac;
  cur_word_t view_one;
  cur_word_t view_two;

  reconfig_source_pick u_pick (
    .cfg_reset(external_config_reset_pin),
    .crc_error(crc_error),
    .err_pin(external_error_pin),
    .watchdog(watchdog_timeout),
    .fabric_req(fabric_reconfig_req),
    .onehot(cause)
  );

  // Any single source ends a running application image
  assign any_cause = |cause; // see (R1)

  // Encodes 00 factory, 01 app loading, 10 app user, 11 reconfiguring
  always_comb begin
    unique case (st_q.phase)
      ST_FACTORY: mstate = `MSTATE_FACTORY; // see (R19)
      ST_APP: mstate = app_user_mode ? `MSTATE_APP_USER : `MSTATE_APP_LOAD;
      ST_LEAVING: mstate = `MSTATE_RECONFIG;
      default: mstate = `MSTATE_RECONFIG;
    endcase
  end

  // Views are only meaningful for active serial or parallel schemes
  assign scheme_supported = 1'b1; // see (R9)

  always_comb begin
    view_fac = {mstate, {`PAD_W{1'b0}}, st_q.run_addr}; // see (R3) (R4) (R5)
    view_two = {mstate, {`PAD_W{1'b0}}, st_q.run_addr}; // see (R4) (R5)
    view_one = {mstate, wd_enable, wd_timeout}; // see (R6) (R7)
  end

  always_comb begin
    st_d = st_q;
    st_d.shift_vld = 1'b0;
    st_d.updated = 1'b0;
    unique case (st_q.phase)
      ST_FACTORY: begin
        if (running_app) begin
          st_d.phase = ST_APP;
          st_d.app_seen = 1'b1;
          st_d.run_addr = boot_addr;
        end else begin
          st_d.run_addr = boot_addr;
        end
      end
      ST_APP: begin
        // Capture the leaving image before the factory image loads
        if (any_cause) begin
          st_d.rec_two = st_q.rec_one; // see (R10) (R11)
          st_d.rec_one = {cause, mstate, st_q.run_addr}; // see (R12) (R14) (R15) (R18)
          st_d.updated = 1'b1;
          st_d.phase = ST_LEAVING;
        end
      end
      ST_LEAVING: begin
        if (running_app) begin
          st_d.phase = ST_APP;
          st_d.run_addr = boot_addr;
        end else begin
          st_d.phase = ST_FACTORY;
          st_d.run_addr = boot_addr;
        end
      end
      default: st_d.phase = ST_FACTORY;
    endcase
    // Capture reads the old record, so one taken with an exit sees it unmoved
    if (capture) begin
      st_d.shift_vld = 1'b1; // see (R17)
      case (capture_sel)
        `SEL_CUR_FACTORY: st_d.shift = view_fac;
        `SEL_CUR_APP_ONE: st_d.shift = view_one;
        `SEL_CUR_APP_TWO: st_d.shift = view_two;
        `SEL_PREV_ONE: st_d.shift = {1'b0, st_q.app_seen ? st_q.rec_one : `INVALID_PREV}; // see (R16)
        `SEL_PREV_TWO: st_d.shift = {1'b0, st_q.app_seen ? st_q.rec_two : `INVALID_PREV};
        default: st_d.shift = {1'b0, `INVALID_PREV};
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '{phase: ST_FACTORY, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Factory view in factory image, application view two otherwise
  always_comb begin
    if (st_q.phase == ST_FACTORY) begin
      current_state_word = view_fac; // see (R8) (R2)
    end else begin
      current_state_word = view_two;
    end
  end

  assign shift_data = st_q.shift;
  assign shift_valid = st_q.shift_vld;
  assign previous_state_record_one = st_q.rec_one;
  assign previous_state_record_two = st_q.rec_two;
  assign record_updated = st_q.updated;

  // Both schemes share one layout, so the select pins go unread
  wire logic unused_pins = ^scheme_select_pins;

  sequence app_exit_s;
    st_q.phase == ST_APP && any_cause;
  endsequence

  cause_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    any_cause |-> $onehot(cause)) else $error("cause not one-hot"); // see (R13)
  reset_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    external_config_reset_pin |-> cause == `SRC_CFG_RESET) else $error("config reset lost priority"); // see (R13)
  record_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    app_exit_s |=> record_updated && previous_state_record_two == $past(previous_state_record_one))
    else $error("older record not shifted"); // see (R11)
  record_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    app_exit_s |=> previous_state_record_one[`PREV_SRC_HI:`PREV_SRC_LO] == $past(cause))
    else $error("cause field wrong"); // see (R12)
  record_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    app_exit_s |=> previous_state_record_one[`ADDR_W-1:0] == $past(st_q.run_addr))
    else $error("address field wrong"); // see (R15)
  record_mstate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    app_exit_s |=> previous_state_record_one[`PREV_MSTATE_HI:`PREV_MSTATE_LO] == $past(mstate))
    else $error("state field wrong"); // see (R14)
  capture_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture |=> shift_valid ##1 !shift_valid || $past(capture)) else $error("capture strobe wrong"); // see (R17)
  invalid_prev_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_PREV_ONE && !st_q.app_seen |=> shift_data == {1'b0, `INVALID_PREV})
    else $error("premature capture not marked"); // see (R16)
  view_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_CUR_APP_ONE |=>
    shift_data[`CUR_WD_EN_BIT] == $past(wd_enable) && shift_data[`WD_VAL_W-1:0] == $past(wd_timeout))
    else $error("watchdog view wrong"); // see (R6) (R7)
  pad_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    current_state_word[`CUR_WD_EN_BIT:`ADDR_W] == '0) else $error("padding not zero"); // see (R4)
  factory_mstate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase == ST_FACTORY |-> current_state_word[`CUR_MSTATE_HI:`CUR_MSTATE_LO] == `MSTATE_FACTORY)
    else $error("factory state code wrong"); // see (R3) (R8)

  // Phase walk; leaving lasts one cycle so a cause held up to two cycles is never taken twice
  sequence factory_stay_s;
    st_q.phase == ST_FACTORY && !running_app;
  endsequence

  sequence app_entry_s;
    st_q.phase == ST_FACTORY && running_app;
  endsequence

  sequence back_to_app_s;
    st_q.phase == ST_LEAVING && running_app;
  endsequence

  sequence back_to_factory_s;
    st_q.phase == ST_LEAVING && !running_app;
  endsequence

  sequence no_exit_s;
    st_q.phase != ST_APP;
  endsequence

  phase_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $onehot(st_q.phase)) else $error("phase code not one-hot"); // see (R8)
  factory_stay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    factory_stay_s |=> st_q.phase == ST_FACTORY && st_q.run_addr == $past(boot_addr))
    else $error("factory address not followed"); // see (R5) (R8)
  app_entry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    app_entry_s |=> st_q.phase == ST_APP && st_q.app_seen && st_q.run_addr == $past(boot_addr))
    else $error("application entry wrong"); // see (R5) (R8) (R16)
  leave_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    app_exit_s |=> st_q.phase == ST_LEAVING) else $error("exit did not leave image"); // see (R18)
  leave_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase == ST_LEAVING |=> st_q.phase != ST_LEAVING)
    else $error("leaving phase held too long"); // see (R18)
  return_app_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    back_to_app_s |=> st_q.phase == ST_APP && st_q.run_addr == $past(boot_addr))
    else $error("application reload wrong"); // see (R5) (R8)
  return_factory_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    back_to_factory_s |=> st_q.phase == ST_FACTORY && st_q.run_addr == $past(boot_addr))
    else $error("factory reload wrong"); // see (R5) (R8)
  seen_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.app_seen |=> st_q.app_seen) else $error("entry flag lost"); // see (R16)
  app_seen_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase == ST_APP |-> st_q.app_seen) else $error("image run without entry flag"); // see (R16)

  // Records move only on an exit from an application image
  records_frozen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    no_exit_s |=> !record_updated && $stable(previous_state_record_one) && $stable(previous_state_record_two))
    else $error("record moved outside an exit"); // see (R10) (R18)
  update_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    record_updated |=> !record_updated) else $error("update flag held"); // see (R18)
  update_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    record_updated |-> $past(st_q.phase == ST_APP && any_cause))
    else $error("update without a cause"); // see (R1) (R18)
  record_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    record_updated |-> $onehot(previous_state_record_one[`PREV_SRC_HI:`PREV_SRC_LO]))
    else $error("stored cause not one-hot"); // see (R12)

  // Master-state code as seen in the live word
  mstate_user_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase == ST_APP && app_user_mode |-> current_state_word[`CUR_MSTATE_HI:`CUR_MSTATE_LO] == `MSTATE_APP_USER)
    else $error("user-mode state code wrong"); // see (R3) (R19)
  mstate_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase == ST_APP && !app_user_mode |-> current_state_word[`CUR_MSTATE_HI:`CUR_MSTATE_LO] == `MSTATE_APP_LOAD)
    else $error("loading state code wrong"); // see (R3) (R19)
  mstate_leave_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase == ST_LEAVING |-> current_state_word[`CUR_MSTATE_HI:`CUR_MSTATE_LO] == `MSTATE_RECONFIG)
    else $error("leaving state code wrong"); // see (R3) (R19)
  cur_factory_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase == ST_FACTORY |-> current_state_word == {`MSTATE_FACTORY, {`PAD_W{1'b0}}, st_q.run_addr})
    else $error("factory live word wrong"); // see (R2) (R5) (R8)
  cur_app_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.phase != ST_FACTORY |-> current_state_word[`ADDR_W-1:0] == st_q.run_addr)
    else $error("application live address wrong"); // see (R5) (R8)

  // Priority ladder; the picker must never flag two sources
  crc_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    crc_error && !external_config_reset_pin |-> cause == `SRC_CRC)
    else $error("crc source lost priority"); // see (R13)
  err_pin_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    external_error_pin && !external_config_reset_pin && !crc_error |-> cause == `SRC_ERR_PIN)
    else $error("error pin source lost priority"); // see (R13)
  watchdog_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    watchdog_timeout && !external_config_reset_pin && !crc_error && !external_error_pin
    |-> cause == `SRC_WATCHDOG)
    else $error("watchdog source lost priority"); // see (R13)
  fabric_last_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fabric_reconfig_req && !external_config_reset_pin && !crc_error && !external_error_pin && !watchdog_timeout
    |-> cause == `SRC_FABRIC)
    else $error("fabric source not flagged"); // see (R1) (R13)
  no_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !external_config_reset_pin && !crc_error && !external_error_pin && !watchdog_timeout && !fabric_reconfig_req
    |-> !any_cause)
    else $error("cause flagged with no source"); // see (R1)

  // Capture path, one check per selector code
  cap_factory_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_CUR_FACTORY
    |=> shift_data == {$past(mstate), {`PAD_W{1'b0}}, $past(st_q.run_addr)})
    else $error("factory view capture wrong"); // see (R3) (R4) (R5)
  cap_app_two_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_CUR_APP_TWO
    |=> shift_data == {$past(mstate), {`PAD_W{1'b0}}, $past(st_q.run_addr)})
    else $error("second view capture wrong"); // see (R3) (R4) (R5)
  cap_one_state_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_CUR_APP_ONE |=> shift_data[`CUR_MSTATE_HI:`CUR_MSTATE_LO] == $past(mstate))
    else $error("first view state code wrong"); // see (R3)
  cap_prev_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_PREV_ONE && st_q.app_seen
    |=> shift_data == {1'b0, $past(previous_state_record_one)})
    else $error("first record capture wrong"); // see (R11) (R17)
  cap_prev_two_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_PREV_TWO && st_q.app_seen
    |=> shift_data == {1'b0, $past(previous_state_record_two)})
    else $error("second record capture wrong"); // see (R11) (R17)
  invalid_two_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel == `SEL_PREV_TWO && !st_q.app_seen |=> shift_data == {1'b0, `INVALID_PREV})
    else $error("premature second capture not marked"); // see (R16)
  bad_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel > `SEL_PREV_TWO |=> shift_data == {1'b0, `INVALID_PREV})
    else $error("unknown selector not marked"); // see (R16)
  prev_top_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture && capture_sel >= `SEL_PREV_ONE |=> !shift_data[`CUR_WORD_W-1])
    else $error("record capture top bit set"); // see (R11)
  shift_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !capture |=> !shift_valid && $stable(shift_data)) else $error("shift word moved unasked"); // see (R17)
  shift_source_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    shift_valid |-> $past(capture)) else $error("valid without capture"); // see (R17)
endmodule

`default_nettype wire

//--- dv/fabric_user_model.sv
// Fabric user logic model: requests captures and reads the shifted word.
// Assumes the capture contract: pulse taken at an edge, valid one cycle later.
`default_nettype none

module fabric_user_model (
  input wire logic core_clk,
  input wire logic shift_valid,
  input wire logic [31:0] shift_data,
  output logic capture,
  output reconfig_status_pkg::sel_t capture_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  import reconfig_status_pkg::*;

  initial begin
    capture = 1'b0;
    capture_sel = 3'h0;
  end

  // Select flips after release so a stale code is never mistaken for a held one
  task automatic grab(input sel_t sel, output logic [31:0] word, output logic seen);
    @(posedge core_clk);
    capture <= 1'b1;
    capture_sel <= sel;
    @(posedge core_clk);
    capture <= 1'b0;
    capture_sel <= ~sel;
    #1;
    seen = shift_valid;
    word = shift_data;
  endtask
endmodule

`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the reconfiguration cause and status record.
// Assumes the fabric user model drives the capture port.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, running_app, app_user_mode, wd_enable;
  logic crc_error, external_error_pin, fabric_reconfig_req, external_config_reset_pin, watchdog_timeout;
  logic [1:0] scheme_select_pins;
  logic [23:0] boot_addr, addr;
  logic [28:0] wd_timeout;
  logic capture, shift_valid, record_updated, scheme_supported;
  logic [2:0] capture_sel;
  logic [31:0] shift_data, current_state_word;
  logic [30:0] previous_state_record_one, previous_state_record_two, exp1, exp2;
  int failures, checks, cycles;

  reconfig_cause_status_record dut (.core_clk(core_clk), .rst_n(rst_n), .scheme_select_pins(scheme_select_pins),
    .running_app(running_app), .app_user_mode(app_user_mode), .boot_addr(boot_addr), .wd_enable(wd_enable),
    .wd_timeout(wd_timeout), .crc_error(crc_error), .external_error_pin(external_error_pin),
    .fabric_reconfig_req(fabric_reconfig_req), .external_config_reset_pin(external_config_reset_pin),
    .watchdog_timeout(watchdog_timeout), .capture(capture), .capture_sel(capture_sel), .shift_data(shift_data),
    .shift_valid(shift_valid), .current_state_word(current_state_word),
    .previous_state_record_one(previous_state_record_one), .previous_state_record_two(previous_state_record_two),
    .record_updated(record_updated), .scheme_supported(scheme_supported));

  fabric_user_model u_fab (.core_clk(core_clk), .shift_valid(shift_valid), .shift_data(shift_data),
    .capture(capture), .capture_sel(capture_sel));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("Counts: checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic cap(input logic [2:0] sel, input logic [31:0] want);
    logic [31:0] w;
    logic v;
    u_fab.grab(sel, w, v);
    chk({31'h0, v}, 32'h1);
    chk(w, want);
  endtask

  // One cause pulse; the image re-entered afterwards loads from next_addr
  task automatic hit(input logic [4:0] vec, input logic [4:0] src, input logic [23:0] next_addr);
    @(posedge core_clk);
    {external_config_reset_pin, crc_error, external_error_pin, watchdog_timeout, fabric_reconfig_req} <= vec;
    exp2 = exp1;
    exp1 = {src, app_user_mode ? 2'h2 : 2'h1, addr};
    @(posedge core_clk);
    {external_config_reset_pin, crc_error, external_error_pin, watchdog_timeout, fabric_reconfig_req} <= 5'h00;
    addr = next_addr;
    boot_addr <= addr;
    #1;
    chk({31'h0, record_updated}, 32'h1);
    chk({1'b0, previous_state_record_one}, {1'b0, exp1});
    chk({1'b0, previous_state_record_two}, {1'b0, exp2});
    repeat (3) @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      stop_test();
    end
  end

  logic [4:0] cause_tab [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1F, 5'h03, 5'h06};
  logic [4:0] src_tab [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10, 5'h02, 5'h04};

  initial begin
    addr = 24'hA5C3F0;
    exp1 = 31'h0;
    rst_n <= 1'b0;
    scheme_select_pins <= 2'h1;
    {running_app, app_user_mode, wd_enable} <= 3'h0;
    {external_config_reset_pin, crc_error, external_error_pin, watchdog_timeout, fabric_reconfig_req} <= 5'h00;
    boot_addr <= addr;
    wd_timeout <= 29'h0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    cap(3'h3, {1'b0, 31'h7FFFFFFF});
    cap(3'h4, {1'b0, 31'h7FFFFFFF});
    cap(3'h0, {2'h0, 6'h00, addr});
    chk(current_state_word, {2'h0, 6'h00, addr});
    chk({31'h0, scheme_supported}, 32'h1);
    @(posedge core_clk);
    addr = 24'h3C0004;
    boot_addr <= addr;
    {running_app, app_user_mode, wd_enable} <= 3'h7;
    wd_timeout <= 29'h1ABCDEF1;
    scheme_select_pins <= 2'h2;
    repeat (3) @(posedge core_clk);
    cap(3'h1, {2'h2, 1'b1, 29'h1ABCDEF1});
    cap(3'h2, {2'h2, 6'h00, addr});
    chk(current_state_word, {2'h2, 6'h00, addr});
    chk({31'h0, scheme_supported}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      app_user_mode <= i[0];
      hit(cause_tab[i], src_tab[i], addr + 24'h011110);
    end
    cap(3'h3, {1'b0, exp1});
    cap(3'h4, {1'b0, exp2});
    cap(3'h5, {1'b0, 31'h7FFFFFFF});
    @(posedge core_clk);
    running_app <= 1'b0;
    hit(5'h08, 5'h08, addr);
    crc_error <= 1'b1;
    @(posedge core_clk);
    crc_error <= 1'b0;
    #1;
    chk({31'h0, record_updated}, 32'h0);
    chk({1'b0, previous_state_record_one}, {1'b0, exp1});
    cap(3'h0, {2'h0, 6'h00, addr});
    stop_test();
  end
endmodule

`default_nettype wire
